// *** src/tcr_pkg.sv ***
// Functional notes
// R1: 16-bit register, two bytes, high first
// R2: high bit7 reads 1 idle, 0 converting
// R3: resolution bits read fixed 11
// R4: fault count code 00/01/10/11 = 1/2/4/6
// R5: alert active level follows polarity bit
// R6: bit1 selects interrupt or comparator alert
// R7: bit0 shutdown, zero means continuous conversion
// R8: rate code 0.25, 1, 4, 8 Hz
// R9: polarity 0 flag drops at high, rises below low
// R10: polarity 1 inverts the flag value
// R11: alert mode never alters the flag
// R12: extended bit selects 13-bit formats; code applies it to the limits only, temperature format follows sample.wide
// R13: interrupt mode alert cleared by alert response
// R14: general call reset restores power-up values
// R15: low bits 3:0 read zero, status unwritable
// R16: whole register resets to 60a0
package tcr_pkg;

  localparam logic [15:0] TCR_RESET_VALUE = 16'h60a0;
  localparam int          TCR_POS_IDLE    = 15;
  localparam int          TCR_POS_RES_HI  = 14;
  localparam int          TCR_POS_RES_LO  = 13;
  localparam int          TCR_POS_FLT_HI  = 12;
  localparam int          TCR_POS_FLT_LO  = 11;
  localparam int          TCR_POS_POL     = 10;
  localparam int          TCR_POS_TM      = 9;
  localparam int          TCR_POS_SD      = 8;
  localparam int          TCR_POS_RATE_HI = 7;
  localparam int          TCR_POS_RATE_LO = 6;
  localparam int          TCR_POS_TRIP    = 5;
  localparam int          TCR_POS_EM      = 4;
  // writable bits: faults, polarity, mode, shutdown, rate, extended
  localparam logic [15:0] TCR_WRITE_MASK  = 16'h1fd0;

  localparam real         TCR_CLK_MHZ     = 100.0;
  // conversion time of one sample
  localparam real         TCR_CONV_MS     = 26.0;
  localparam int          TCR_CONV_CYC    = int'(TCR_CONV_MS * TCR_CLK_MHZ
                                                 * 1000.0);
  localparam real         TCR_PER_025_MS  = 4000.0;
  localparam real         TCR_PER_1_MS    = 1000.0;
  localparam real         TCR_PER_4_MS    = 250.0;
  localparam real         TCR_PER_8_MS    = 125.0;
  localparam int          TCR_PER_025_CYC = int'(TCR_PER_025_MS
                                                 * TCR_CLK_MHZ * 1000.0);
  localparam int          TCR_PER_1_CYC   = int'(TCR_PER_1_MS
                                                 * TCR_CLK_MHZ * 1000.0);
  localparam int          TCR_PER_4_CYC   = int'(TCR_PER_4_MS
                                                 * TCR_CLK_MHZ * 1000.0);
  localparam int          TCR_PER_8_CYC   = int'(TCR_PER_8_MS
                                                 * TCR_CLK_MHZ * 1000.0);

  typedef struct packed {
    logic       wr_hi;
    logic       wr_lo;
    logic [7:0] wdata;
  } tcr_wr_type;

  typedef struct packed {
    logic        valid;
    logic        wide;
    logic [12:0] temp;
  } tcr_sample_type;

endpackage

// *** src/tcr_fault_filter.sv ***
`timescale 1ns/1ps
// ************************************************************
// consecutive fault filter
// ************************************************************
module tcr_fault_filter
  import tcr_pkg::*;
#(
  parameter int WIDTH = 13
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             sample_valid,
  input  wire logic [WIDTH-1:0] temp,
  input  wire logic [WIDTH-1:0] high_limit,
  input  wire logic [WIDTH-1:0] low_limit,
  input  wire logic [1:0]       fault_sel,
  output logic                  tripped
);

  initial begin
    if (WIDTH < 2) $error("width too small");
  end

  logic [2:0] hi_cnt_reg;
  logic [2:0] lo_cnt_reg;
  logic       trip_reg;
  logic [2:0] need;
  wire        at_high = $signed(temp) >= $signed(high_limit);
  wire        below_low = $signed(temp) < $signed(low_limit);

  // fault count code to count
  function automatic logic [2:0] fault_need(input logic [1:0] sel);
    unique case (sel)
      2'h0: fault_need = 3'h1;
      2'h1: fault_need = 3'h2;
      2'h2: fault_need = 3'h4;
      2'h3: fault_need = 3'h6;
    endcase
  endfunction

  assign need = fault_need(fault_sel); // see R4

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt_reg <= 3'h0;
      lo_cnt_reg <= 3'h0;
      trip_reg   <= 1'b0;
    end else if (clear) begin
      hi_cnt_reg <= 3'h0;
      lo_cnt_reg <= 3'h0;
      trip_reg   <= 1'b0;
    end else if (sample_valid) begin
      hi_cnt_reg <= at_high && hi_cnt_reg < 3'h6 ? hi_cnt_reg + 3'h1
                  : (at_high ? hi_cnt_reg : 3'h0);
      lo_cnt_reg <= below_low && lo_cnt_reg < 3'h6 ? lo_cnt_reg + 3'h1
                  : (below_low ? lo_cnt_reg : 3'h0);
      if (at_high && hi_cnt_reg + 3'h1 >= need)
        trip_reg <= 1'b1; // see R9
      else if (below_low && lo_cnt_reg + 3'h1 >= need)
        trip_reg <= 1'b0; // see R9
    end
  end

  assign tripped = trip_reg;

endmodule // tcr_fault_filter

// *** src/tcr_config_reg.sv ***
`timescale 1ns/1ps
// ************************************************************
// configuration register with conversion pacing and alert
// ************************************************************
module tcr_config_reg
  import tcr_pkg::*;
#(
  parameter int CONV_CYC    = TCR_CONV_CYC,
  parameter int PER_025_CYC = TCR_PER_025_CYC,
  parameter int PER_1_CYC   = TCR_PER_1_CYC,
  parameter int PER_4_CYC   = TCR_PER_4_CYC,
  parameter int PER_8_CYC   = TCR_PER_8_CYC
) (
  input  wire logic           sys_clk,
  input  wire logic           rstn,
  input  wire tcr_wr_type     wr,
  input  wire logic           rd_hi,
  input  wire logic           gen_call_reset,
  input  wire logic           alert_resp_done,
  input  wire tcr_sample_type sample,
  input  wire logic [12:0]    high_limit,
  input  wire logic [12:0]    low_limit,
  output logic [7:0]          rdata,
  output logic [15:0]         config_value,
  output logic                conv_start,
  output logic                alert_out,
  output logic                alert_pending
);

  initial begin
    if (CONV_CYC < 1 || PER_8_CYC <= CONV_CYC) $error("bad timing");
    if (PER_025_CYC < PER_1_CYC || PER_1_CYC < PER_4_CYC
        || PER_4_CYC < PER_8_CYC)
      $error("bad periods");
  end

  // ************************************************************
  // storage
  // ************************************************************
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [31:0] rate_cnt_reg;
  logic [31:0] conv_cnt_reg;
  logic        converting_reg;
  logic        start_reg;
  logic        irq_reg;
  logic        trip_seen_reg;
  logic [7:0]  rdata_reg;
  logic        alert_reg;
  logic        tripped;
  logic [31:0] period;
  logic        trip_flag;
  logic        power_down;
  logic        irq_mode;
  logic        polarity;
  logic        active;

  function automatic logic [31:0] rate_period(input logic [1:0] code);
    unique case (code)
      2'h0: rate_period = 32'(PER_025_CYC);
      2'h1: rate_period = 32'(PER_1_CYC);
      2'h2: rate_period = 32'(PER_4_CYC);
      2'h3: rate_period = 32'(PER_8_CYC);
    endcase
  endfunction

  assign power_down = cfg_reg[TCR_POS_SD];
  assign irq_mode   = cfg_reg[TCR_POS_TM];
  assign polarity   = cfg_reg[TCR_POS_POL];
  assign period     = rate_period(cfg_reg[TCR_POS_RATE_HI:
                                          TCR_POS_RATE_LO]); // see R8
  // see R10 see R11: flag independent of mode
  assign trip_flag  = ~tripped ^ polarity; // see R9

  // writes touch only writable bits
  always_comb begin
    cfg_next = cfg_reg;
    if (wr.wr_hi)
      cfg_next[15:8] = (cfg_reg[15:8] & ~TCR_WRITE_MASK[15:8])
                     | (wr.wdata & TCR_WRITE_MASK[15:8]); // see R15
    if (wr.wr_lo)
      cfg_next[7:0] = (cfg_reg[7:0] & ~TCR_WRITE_MASK[7:0])
                    | (wr.wdata & TCR_WRITE_MASK[7:0]); // see R15
    cfg_next[TCR_POS_IDLE]   = ~converting_reg; // see R2
    cfg_next[TCR_POS_RES_HI] = 1'b1; // see R3
    cfg_next[TCR_POS_RES_LO] = 1'b1; // see R3
    cfg_next[TCR_POS_TRIP]   = trip_flag;
    cfg_next[3:0]            = 4'h0; // see R15
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      cfg_reg <= TCR_RESET_VALUE; // see R16
    else if (gen_call_reset)
      cfg_reg <= TCR_RESET_VALUE; // see R14
    else
      cfg_reg <= cfg_next; // see R1
  end

  // ************************************************************
  // conversion pacing
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rate_cnt_reg   <= 32'h0;
      conv_cnt_reg   <= 32'h0;
      converting_reg <= 1'b0;
      start_reg      <= 1'b0;
    end else if (gen_call_reset) begin
      rate_cnt_reg   <= 32'h0; // see R14
      conv_cnt_reg   <= 32'h0;
      converting_reg <= 1'b0;
      start_reg      <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (converting_reg) begin
        conv_cnt_reg <= conv_cnt_reg + 32'h1;
        if (conv_cnt_reg >= 32'(CONV_CYC - 1))
          converting_reg <= 1'b0;
      end
      if (power_down) begin
        rate_cnt_reg <= 32'h0; // see R7
      end else if (rate_cnt_reg >= period - 32'h1) begin
        rate_cnt_reg   <= 32'h0;
        converting_reg <= 1'b1;
        conv_cnt_reg   <= 32'h0;
        start_reg      <= 1'b1;
      end else begin
        rate_cnt_reg <= rate_cnt_reg + 32'h1;
      end
    end
  end

  // ************************************************************
  // threshold comparison
  // ************************************************************
  tcr_fault_filter #(
    .WIDTH (13)
  ) u_filter (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .clear        (gen_call_reset),
    .sample_valid (sample.valid),
    .temp         (sample.wide ? sample.temp
                   : {sample.temp[12], sample.temp[12:1]}), // see R12
    .high_limit   (cfg_reg[TCR_POS_EM] ? high_limit
                   : {high_limit[12], high_limit[12:1]}),
    .low_limit    (cfg_reg[TCR_POS_EM] ? low_limit
                   : {low_limit[12], low_limit[12:1]}),
    .fault_sel    (cfg_reg[TCR_POS_FLT_HI:TCR_POS_FLT_LO]), // see R4
    .tripped      (tripped)
  );

  // ************************************************************
  // alert output
  // ************************************************************
  // interrupt: each trip change latches until alert response
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg       <= 1'b0;
      trip_seen_reg <= 1'b0;
    end else if (gen_call_reset) begin
      irq_reg       <= 1'b0;
      trip_seen_reg <= 1'b0;
    end else begin
      trip_seen_reg <= tripped;
      if (tripped != trip_seen_reg)
        irq_reg <= 1'b1; // set wins over clear
      else if (alert_resp_done)
        irq_reg <= 1'b0; // see R13
    end
  end

  assign active = irq_mode ? irq_reg : tripped; // see R6

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_reg <= 1'b1;
      rdata_reg <= 8'h0;
    end else begin
      alert_reg <= active ~^ polarity; // see R5
      rdata_reg <= rd_hi ? cfg_reg[15:8] : cfg_reg[7:0]; // see R1
    end
  end

  assign rdata         = rdata_reg;
  assign config_value  = cfg_reg;
  assign conv_start    = start_reg;
  assign alert_out     = alert_reg;
  assign alert_pending = irq_reg;

  // ************************************************************
  // checks
  // ************************************************************
  property p_fixed_bits;
    @(posedge sys_clk) disable iff (!rstn)
      cfg_reg[14:13] == 2'h3 && cfg_reg[3:0] == 4'h0;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) // see R3
    else $error("fixed bits wrong");

  property p_idle_flag;
    @(posedge sys_clk) disable iff (!rstn)
      start_reg |=> !cfg_reg[TCR_POS_IDLE];
  endproperty
  a_idle_flag: assert property (p_idle_flag) // see R2
    else $error("idle flag not cleared");

  property p_shutdown;
    @(posedge sys_clk) disable iff (!rstn)
      power_down |=> !start_reg;
  endproperty
  a_shutdown: assert property (p_shutdown) // see R7
    else $error("conversion in shutdown");

  property p_polarity;
    @(posedge sys_clk) disable iff (!rstn || gen_call_reset)
      !irq_mode && $stable(cfg_reg[TCR_POS_POL]) && $stable(tripped)
      |=> alert_reg == ($past(tripped) ~^ $past(polarity));
  endproperty
  a_polarity: assert property (p_polarity) // see R5
    else $error("alert level wrong");

  property p_flag;
    @(posedge sys_clk) disable iff (!rstn || gen_call_reset)
      1'b1 |=> cfg_reg[TCR_POS_TRIP] == ($past(~tripped) ^ $past(polarity));
  endproperty
  a_flag: assert property (p_flag) // see R10
    else $error("trip flag wrong");

  property p_ro_write;
    @(posedge sys_clk) disable iff (!rstn || gen_call_reset)
      wr.wr_hi |=> cfg_reg[14:13] == 2'h3
                   && (cfg_reg[15:8] & TCR_WRITE_MASK[15:8])
                      == ($past(wr.wdata) & TCR_WRITE_MASK[15:8]);
  endproperty
  a_ro_write: assert property (p_ro_write) // see R15
    else $error("read-only bit written");

  property p_gcr;
    @(posedge sys_clk) disable iff (!rstn)
      gen_call_reset |=> cfg_reg == TCR_RESET_VALUE && !converting_reg;
  endproperty
  a_gcr: assert property (p_gcr) // see R14
    else $error("general call reset failed");

  property p_irq_clear;
    @(posedge sys_clk) disable iff (!rstn || gen_call_reset)
      alert_resp_done && tripped == trip_seen_reg |=> !irq_reg;
  endproperty
  a_irq_clear: assert property (p_irq_clear) // see R13
    else $error("alert not cleared");

  property p_write_lo;
    @(posedge sys_clk) disable iff (!rstn || gen_call_reset)
      wr.wr_lo && !wr.wr_hi |=> cfg_reg[TCR_POS_EM] == $past(wr.wdata[4]);
  endproperty
  a_write_lo: assert property (p_write_lo) // see R12
    else $error("extended bit not stored");

endmodule // tcr_config_reg

// *** dv/tcr_host_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// two-wire host controller model, register side
// ************************************************************
module tcr_host_model
  import tcr_pkg::*;
(
  input  wire logic       sys_clk,
  output tcr_wr_type      wr,
  output logic            rd_hi,
  output logic            gen_call_reset,
  output logic            alert_resp_done,
  input  wire logic [7:0] rdata
);
  initial begin
    wr              = '0;
    rd_hi           = 1'b0;
    gen_call_reset  = 1'b0;
    alert_resp_done = 1'b0;
  end

  // high byte first, then low byte
  task automatic write_cfg(input logic [15:0] v);
    @(posedge sys_clk) #1;
    wr = '{1'b1, 1'b0, v[15:8]};
    @(posedge sys_clk) #1;
    wr = '{1'b0, 1'b1, v[7:0]};
    @(posedge sys_clk) #1;
    wr = '{1'b0, 1'b0, ~v[7:0]};
  endtask

  task automatic read_cfg(output logic [15:0] v);
    @(posedge sys_clk) #1;
    rd_hi = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    v[15:8] = rdata;
    rd_hi = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    v[7:0] = rdata;
  endtask

  // general call with 06h, or alert response returning own address
  task automatic pulse(input logic gc);
    @(posedge sys_clk) #1;
    if (gc) gen_call_reset = 1'b1;
    else alert_resp_done = 1'b1;
    @(posedge sys_clk) #1;
    gen_call_reset  = 1'b0;
    alert_resp_done = 1'b0;
  endtask
endmodule // tcr_host_model

// *** dv/temp_sensor_config_register_tb_top.sv ***
`timescale 1ns/1ps
module temp_sensor_config_register_tb_top;
  import tcr_pkg::*;
  logic           sys_clk = 1'b0;
  logic           rstn;
  tcr_wr_type     wr;
  logic           rd_hi, gen_call_reset, alert_resp_done;
  tcr_sample_type sample;
  logic [12:0]    high_limit;
  logic [12:0]    low_limit;
  logic [7:0]     rdata;
  logic [15:0]    config_value, rv;
  logic           conv_start, alert_out, alert_pending;
  int             err_count = 0;
  int             cmp_count = 0;
  int             n;
  typedef struct { logic [15:0] w; logic [15:0] e; } tcr_row_type;
  tcr_row_type rows[4] = '{'{16'hffff, 16'h7fd0}, '{16'h0000, 16'h6000},
                    '{16'h1250, 16'h7250}, '{16'h0a9f, 16'h6a90}};
  int   faults[4] = '{1, 2, 4, 6};
  int   pers[4]   = '{128, 64, 32, 16};

  always #5 sys_clk = ~sys_clk;

  tcr_config_reg #(.CONV_CYC(4), .PER_025_CYC(128), .PER_1_CYC(64),
                   .PER_4_CYC(32), .PER_8_CYC(16)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .wr(wr), .rd_hi(rd_hi),
    .gen_call_reset(gen_call_reset), .alert_resp_done(alert_resp_done),
    .sample(sample), .high_limit(high_limit), .low_limit(low_limit),
    .rdata(rdata), .config_value(config_value), .conv_start(conv_start),
    .alert_out(alert_out), .alert_pending(alert_pending));

  tcr_host_model host (.sys_clk(sys_clk), .wr(wr), .rd_hi(rd_hi),
    .gen_call_reset(gen_call_reset), .alert_resp_done(alert_resp_done),
    .rdata(rdata));

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp=%h seen=%h", name, exp, seen);
    end
  endtask

  // one sample pulse, then let the filter settle
  task automatic send(input logic wide, input logic [12:0] t);
    @(posedge sys_clk) #1;
    sample = '{1'b1, wide, t};
    @(posedge sys_clk) #1;
    sample.valid = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_start(output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk) #1;
      cnt++;
    end while (conv_start !== 1'b1 && cnt < 400);
  endtask

  task automatic stop_test;
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    stop_test;
  end

  initial begin
    rstn       = 1'b0;
    sample     = '0;
    high_limit = 13'd200;
    low_limit  = 13'd180;
    repeat (6) @(posedge sys_clk);
    check("reset", config_value, 16'h60a0);
    check("rst_alrt", alert_out, 1'b1);
    check("rst_rdat", rdata, 8'h00);
    check("rst_strt", conv_start, 1'b0);
    #1 rstn = 1'b1;
    // ************************************************************
    // table: write, read back through both bytes
    // ************************************************************
    foreach (rows[i]) begin
      host.write_cfg(rows[i].w);
      host.read_cfg(rv);
      check("rd", rv & 16'h7fdf, rows[i].e);
      check("cfg", config_value & 16'h7fdf, rows[i].e);
    end
    // ************************************************************
    // shutdown, then conversion rates
    // ************************************************************
    host.write_cfg(16'h0180);
    wait_start(n);
    check("sd", n[15:0], 16'd400);
    check("idle", config_value[15], 1'b1);
    for (int c = 0; c < 4; c++) begin
      host.write_cfg({8'h00, c[1:0], 6'h00});
      wait_start(n);
      wait_start(n);
      check("rate", n[15:0], pers[c][15:0]);
    end
    // ************************************************************
    // fault counts, comparator mode, polarity 0
    // ************************************************************
    for (int c = 0; c < 4; c++) begin
      host.write_cfg({3'b000, c[1:0], 3'b000, 8'h80});
      repeat (faults[c] - 1) send(1'b0, 13'd220);
      check("pre", config_value[5], 1'b1);
      send(1'b0, 13'd220);
      check("trip", config_value[5], 1'b0);
      check("alrt", alert_out, 1'b0);
      repeat (faults[c] - 1) send(1'b0, 13'd160);
      check("hold", config_value[5], 1'b0);
      send(1'b0, 13'd160);
      check("clr", config_value[5], 1'b1);
    end
    // polarity 1 inverts flag and pin
    host.write_cfg(16'h0480);
    check("p1", config_value[5], 1'b0);
    send(1'b0, 13'd200);
    check("p1t", config_value[5], 1'b1);
    check("p1a", alert_out, 1'b1);
    send(1'b0, 13'd100);
    // ************************************************************
    // interrupt mode and alert response
    // ************************************************************
    host.write_cfg(16'h0280);
    host.pulse(1'b0);
    #1;
    check("pend0", alert_pending, 1'b0);
    send(1'b0, 13'd210);
    check("itf", config_value[5], 1'b0);
    check("pend", alert_pending, 1'b1);
    check("ita", alert_out, 1'b0);
    host.pulse(1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("ack", alert_pending, 1'b0);
    check("acka", alert_out, 1'b1);
    send(1'b0, 13'd100);
    // ************************************************************
    // extended format, then general call reset
    // ************************************************************
    host.write_cfg(16'h0090);
    high_limit = 13'd201;
    low_limit  = 13'd150;
    send(1'b1, 13'd200);
    check("em0", config_value[5], 1'b1);
    send(1'b1, 13'd201);
    check("em1", config_value[5], 1'b0);
    send(1'b1, 13'd100);
    host.write_cfg(16'h1fd0);
    host.pulse(1'b1);
    #1;
    check("gc", config_value & 16'h7fdf, 16'h6080);
    // second reset in mid-run
    #1 rstn = 1'b0;
    @(posedge sys_clk) #1;
    check("mrst_rd", rdata, 8'h00);
    check("mrst_cfg", config_value, 16'h60a0);
    rstn = 1'b1;
    host.read_cfg(rv);
    check("mrst_rb", rv & 16'h7fdf, 16'h6080);
    stop_test;
  end
endmodule // temp_sensor_config_register_tb_top
